// >>> logic/cwf_map.svh
// Offsets, field positions, reset values and timing counts of the continuous frame sender
// Notes on behaviour
// - Send one whole frame for each finished conversion, unprompted; conversions seen during a frame merge into one owed frame.
// - Indicator mode frames carry weight, tare and scale status only, no setpoint bits.
// - Setpoint mode puts setpoint condition bits into the status bytes.
// - Leading start-of-text and trailing checksum are each switched by their own setting.
// - Order: start-of-text 0x02, status bytes first, second, third, weight, tare.
// - Weight field is the displayed gross or net value, six ASCII digits, MSD first.
// - Weight field has no decimal point or sign; status bytes carry those.
// - Non-significant leading zeros of the weight go out as spaces.
// - Tare field follows as six ASCII digits without decimal point.
// - Carriage return 0x0D follows tare, then checksum only when enabled.
// - First status byte bits 2..0 give the decimal point position.
// - Same status byte meanings for standard and short continuous frames.
// - Second status byte bit 0 net, bit 1 negative.
// - Second status byte bit 2 out of range, bit 3 motion.
// - Second status byte bit 4 kilograms, bit 5 always one.
// - Standard mode: second status byte bit 6 set while zero not captured.
// - Third status byte bits 2..0 give the weight unit code.
// - Third status byte bit 3 print request, bit 4 expand, bit 5 one, bit 6 zero; setpoint mode forces bits 4 and 6 to one.
// - Characters go out as start, seven data, even parity, stop; 300 to 9600 baud; the 16-bit divisor at 125 MHz goes no lower than about 1907 baud.
// - Setpoint mode: first byte bits 3,4 report setpoint feeding, bit 6 one.
// - Setpoint mode: second byte bit 6 reports setpoint 1 out of tolerance.
`ifndef CWF_MAP_SVH
`define CWF_MAP_SVH

`define CWF_ADDR_CTRL   4'h0
`define CWF_ADDR_BAUD   4'h4
`define CWF_ADDR_STAT   4'h8
`define CWF_CTRL_RESET  4'h9
`define CWF_CHR_STX     7'h02
`define CWF_CHR_CR      7'h0d
`define CWF_CHR_SPACE   7'h20
`define CWF_IDX_CR      5'h10
`define CWF_IDX_CHK     5'h11
`define CWF_LAST_BIT    4'h9
`define CWF_CLK_HZ      125000000
`define CWF_BAUD_BPS    9600
`define CWF_BAUD_DIV    (`CWF_CLK_HZ / `CWF_BAUD_BPS)

`endif

// >>> logic/cwf_pkg.sv
// Types shared by the continuous frame sender
package cwf_pkg;

  typedef enum logic [1:0] {CWF_IDLE, CWF_LOAD, CWF_SHIFT} cwf_fsm_t;

  // Scale readings and flags offered each conversion
  typedef struct packed {
    logic [23:0] weightBcd;
    logic [23:0] tareBcd;
    logic [2:0]  decPoint;
    logic [1:0]  incCode;
    logic        isNet;
    logic        isNeg;
    logic        outRange;
    logic        motion;
    logic        isKg;
    logic        zeroLost;
    logic [2:0]  unitCode;
    logic        printReq;
    logic        expand10;
    logic        sp1Feed;
    logic        sp2Feed;
    logic        sp1Tol;
  } cwf_meas_t;

  // Control bits: spMode bit 3, chk bit 2, stx bit 1, en bit 0
  typedef struct packed {
    logic spMode;
    logic chk;
    logic stx;
    logic en;
  } cwf_ctrl_t;

  typedef struct packed {
    cwf_fsm_t    fsm;
    logic        pending;
    cwf_meas_t   snap;
    cwf_ctrl_t   frm;
    cwf_ctrl_t   ctrl;
    logic [15:0] baudDiv;
    logic [4:0]  idx;
    logic [6:0]  sum;
    logic [9:0]  shift;
    logic [3:0]  bitCnt;
    logic [15:0] baudCnt;
    logic [15:0] frameCnt;
    logic        waitReq;
    logic [31:0] readData;
  } cwf_state_t;

endpackage : cwf_pkg

// >>> logic/cwf_frame_tx.sv
// Continuous weight frame builder and serial character sender with Avalon-MM registers
`timescale 1ns/100ps
`include "cwf_map.svh"

module cwf_frame_tx #(
  parameter int unsigned BAUD_DIV = `CWF_BAUD_DIV
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              convDone,
  input  wire cwf_pkg::cwf_meas_t meas,
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  output logic                   txd
);

  localparam logic [15:0] BaudDivInit = 16'(BAUD_DIV);

  cwf_pkg::cwf_state_t st_q;
  cwf_pkg::cwf_state_t st_d;
  logic [6:0]          ch;
  logic                charLoad;
  logic                bitEnd;
  logic                adcTake;
  logic                frameStart;
  logic                lastChar;

  // One digit of a six-digit field, blanked while it is a leading zero ahead of position keep
  function automatic logic [6:0] fieldChar(input logic [23:0] bcd, input logic [2:0] pos,
                                           input logic [2:0] keep);
    logic        lead;
    logic [23:0] sh;
    lead = 1'b1;
    for (int k = 0; k < 6; k++) begin
      if (3'(k) <= pos) begin
        lead = lead & (bcd[23-4*k -: 4] == 4'h0);
      end
    end
    sh = bcd >> (5'd20 - {pos, 2'b00});
    fieldChar = (lead && pos < keep) ? `CWF_CHR_SPACE : {3'b011, sh[3:0]};
  endfunction : fieldChar

  // Character at a frame position, taken from the frame's snapshot
  function automatic logic [6:0] frameChar(input logic [4:0] idx, input cwf_pkg::cwf_meas_t m,
                                           input logic sp, input logic [6:0] sum);
    logic [2:0] keep;
    keep = (m.decPoint >= 3'd3) ? 3'(3'd7 - m.decPoint) : 3'd5;
    case (idx)
      5'h00: frameChar = `CWF_CHR_STX;
      // first status byte, feeding setpoints read as zero
      5'h01: frameChar = {sp, 1'b1, sp ? {~m.sp2Feed, ~m.sp1Feed} : m.incCode, m.decPoint};
      5'h02: frameChar = {sp ? m.sp1Tol : m.zeroLost, 1'b1, m.isKg, m.motion, m.outRange,
                          m.isNeg, m.isNet};
      5'h03: frameChar = {sp, 1'b1, sp | m.expand10, m.printReq, m.unitCode};
      `CWF_IDX_CR: frameChar = `CWF_CHR_CR;
      // two's complement of the running sum
      `CWF_IDX_CHK: frameChar = 7'(7'h00 - sum);
      // weight then tare digits, MSD first
      default: frameChar = (idx < 5'd10) ? fieldChar(m.weightBcd, 3'(idx - 5'd4), keep)
                                         : fieldChar(m.tareBcd, 3'(idx - 5'd10), keep);
    endcase
  endfunction : frameChar

  // Decode helpers used by the next-state logic and the checks
  assign ch         = frameChar(st_q.idx, st_q.snap, st_q.frm.spMode, st_q.sum);
  assign charLoad   = (st_q.fsm == cwf_pkg::CWF_LOAD);
  assign bitEnd     = (16'(st_q.baudCnt + 16'd1) >= st_q.baudDiv);
  assign adcTake    = convDone && st_q.ctrl.en;
  assign frameStart = (st_q.fsm == cwf_pkg::CWF_IDLE) && (st_q.pending || adcTake);
  assign lastChar   = (st_q.idx == `CWF_IDX_CHK) || (st_q.idx == `CWF_IDX_CR && !st_q.frm.chk);

  // Next state: register slave and frame sequencer
  always_comb begin
    st_d = st_q;
    // One answer per request, one cycle after it is seen
    st_d.waitReq = 1'b1;
    if ((avs_read || avs_write) && st_q.waitReq) begin
      st_d.waitReq  = 1'b0;
      st_d.readData = 32'h0000_0000;
      if (avs_read) begin
        case (avs_address)
          `CWF_ADDR_CTRL: st_d.readData = {28'h000_0000, st_q.ctrl};
          `CWF_ADDR_BAUD: st_d.readData = {16'h0000, st_q.baudDiv};
          `CWF_ADDR_STAT: st_d.readData = {st_q.frameCnt, 14'h0000, st_q.pending,
                                           st_q.fsm != cwf_pkg::CWF_IDLE};
          default:        st_d.readData = 32'h0000_0000;
        endcase
      end else if (avs_address == `CWF_ADDR_CTRL) begin
        if (avs_byteenable[0]) st_d.ctrl = avs_writedata[3:0];
      end else if (avs_address == `CWF_ADDR_BAUD) begin
        if (avs_byteenable[0]) st_d.baudDiv[7:0] = avs_writedata[7:0];
        if (avs_byteenable[1]) st_d.baudDiv[15:8] = avs_writedata[15:8];
      end
    end

    // a conversion seen while busy is owed one frame
    st_d.pending = st_q.pending | adcTake;
    unique case (st_q.fsm)
      cwf_pkg::CWF_IDLE: begin
        st_d.pending = st_q.pending & adcTake;
        if (frameStart) begin
          // mode and options frozen for the frame
          st_d.snap = meas;
          st_d.frm  = st_q.ctrl;
          st_d.idx  = st_q.ctrl.stx ? 5'h00 : 5'h01;
          st_d.sum  = 7'h00;
          st_d.fsm  = cwf_pkg::CWF_LOAD;
        end
      end
      cwf_pkg::CWF_LOAD: begin
        // start, seven data bits, even parity, stop
        st_d.shift   = {1'b1, ^ch, ch, 1'b0};
        st_d.sum     = 7'(st_q.sum + ch);
        st_d.baudCnt = 16'h0000;
        st_d.bitCnt  = 4'h0;
        st_d.fsm     = cwf_pkg::CWF_SHIFT;
      end
      cwf_pkg::CWF_SHIFT: begin
        st_d.baudCnt = 16'(st_q.baudCnt + 16'd1);
        if (bitEnd) begin
          st_d.baudCnt = 16'h0000;
          st_d.shift   = {1'b1, st_q.shift[9:1]};
          st_d.bitCnt  = 4'(st_q.bitCnt + 4'd1);
          if (st_q.bitCnt == `CWF_LAST_BIT) begin
            // checksum follows CR only when enabled
            if (lastChar) begin
              st_d.fsm      = cwf_pkg::CWF_IDLE;
              st_d.frameCnt = 16'(st_q.frameCnt + 16'd1);
            end else begin
              st_d.idx = 5'(st_q.idx + 5'd1);
              st_d.fsm = cwf_pkg::CWF_LOAD;
            end
          end
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q         <= '0;
      st_q.shift   <= 10'h3ff;
      st_q.waitReq <= 1'b1;
      st_q.ctrl    <= `CWF_CTRL_RESET;
      st_q.baudDiv <= BaudDivInit;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata    = st_q.readData;
  assign avs_waitrequest = st_q.waitReq;
  assign txd             = st_q.shift[0];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_load_at(int n);
    charLoad && st_q.idx == 5'(n);
  endsequence

  sequence s_start_stx;
    frameStart && st_q.ctrl.stx;
  endsequence

  a_frame_owed: assert property (adcTake |=> st_q.pending || st_q.fsm != cwf_pkg::CWF_IDLE)
    else $error("conversion lost without frame");

  a_stx_first: assert property (s_start_stx |=> s_load_at(0) ##0 ch == `CWF_CHR_STX)
    else $error("frame did not open with start-of-text");

  a_stx_skip: assert property (frameStart && !st_q.ctrl.stx |=> s_load_at(1))
    else $error("start-of-text sent while disabled");

  a_cr_code: assert property (s_load_at(16) |-> ch == `CWF_CHR_CR)
    else $error("carriage return wrong");

  a_chk_gate: assert property (charLoad && !st_q.frm.chk |-> st_q.idx != `CWF_IDX_CHK)
    else $error("checksum sent while disabled");

  a_chk_sum: assert property (s_load_at(17) |-> 7'(st_q.sum + ch) == 7'h00)
    else $error("checksum does not cancel sum");

  a_char_frame: assert property (charLoad |=> !txd && (^st_q.shift[8:1]) == 1'b0 && st_q.shift[9])
    else $error("character frame or parity wrong");

  a_byte_a: assert property (s_load_at(1) |-> ch[5] && ch[6] == st_q.frm.spMode)
    else $error("first status byte fixed bits wrong");

  a_byte_b: assert property (s_load_at(2) |-> ch[5] &&
    ch[6] == (st_q.frm.spMode ? st_q.snap.sp1Tol : st_q.snap.zeroLost))
    else $error("second status byte bit 6 or 5 wrong");

  a_digit_ascii: assert property (charLoad && st_q.idx >= 5'd4 && st_q.idx <= 5'd15 |->
    ch == `CWF_CHR_SPACE || (ch[6:4] == 3'b011 && ch[3:0] <= 4'h9))
    else $error("field character not digit or space");

  a_bus_answer: assert property ((avs_read || avs_write) && st_q.waitReq |=>
    !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");

  // End of the stop bit of one character
  sequence s_char_end;
    st_q.fsm == cwf_pkg::CWF_SHIFT && bitEnd && st_q.bitCnt == `CWF_LAST_BIT;
  endsequence

  // Load of a character inside a span of frame positions
  sequence s_load_span(int lo, int hi);
    charLoad && st_q.idx >= 5'(lo) && st_q.idx <= 5'(hi);
  endsequence

  a_idle_high: assert property (st_q.fsm == cwf_pkg::CWF_IDLE |->
    txd)
    else $error("line not high while idle");

  a_load_high: assert property (charLoad |->
    txd)
    else $error("line not high between characters");

  a_start_low: assert property (st_q.fsm == cwf_pkg::CWF_SHIFT && st_q.bitCnt == 4'h0 |->
    !txd)
    else $error("start bit not low");

  a_stop_high: assert property (st_q.fsm == cwf_pkg::CWF_SHIFT && st_q.bitCnt == `CWF_LAST_BIT |->
    txd)
    else $error("stop bit not high");

  a_bit_count: assert property (st_q.fsm == cwf_pkg::CWF_SHIFT |->
    st_q.bitCnt <= `CWF_LAST_BIT)
    else $error("bit counter beyond stop bit");

  a_baud_span: assert property (st_q.fsm == cwf_pkg::CWF_SHIFT |->
    st_q.baudCnt < st_q.baudDiv || st_q.baudCnt == 16'h0000)
    else $error("bit time overran divisor");

  a_next_char: assert property (s_char_end ##0 !lastChar |=>
    charLoad && st_q.idx == 5'($past(st_q.idx) + 5'd1))
    else $error("frame position skipped");

  a_idx_range: assert property (st_q.fsm != cwf_pkg::CWF_IDLE |->
    st_q.idx <= `CWF_IDX_CHK)
    else $error("frame position out of range");

  a_cr_to_chk: assert property (s_char_end ##0 (st_q.idx == `CWF_IDX_CR && st_q.frm.chk) |=>
    s_load_at(17))
    else $error("checksum did not follow carriage return");

  a_cr_last: assert property (s_char_end ##0 (st_q.idx == `CWF_IDX_CR && !st_q.frm.chk) |=>
    st_q.fsm == cwf_pkg::CWF_IDLE)
    else $error("frame went on after carriage return");

  a_chk_last: assert property (s_char_end ##0 st_q.idx == `CWF_IDX_CHK |=>
    st_q.fsm == cwf_pkg::CWF_IDLE)
    else $error("frame went on after checksum");

  a_start_load: assert property (frameStart |=>
    charLoad)
    else $error("frame start did not load a character");

  a_snap_meas: assert property (frameStart |=>
    st_q.snap == $past(meas))
    else $error("readings not captured at frame start");

  a_en_refuse: assert property (convDone && !st_q.ctrl.en && !st_q.pending && st_q.fsm == cwf_pkg::CWF_IDLE |=>
    st_q.fsm == cwf_pkg::CWF_IDLE && !st_q.pending)
    else $error("frame started while disabled");

  a_pending_hold: assert property (st_q.pending && st_q.fsm != cwf_pkg::CWF_IDLE |=>
    st_q.pending)
    else $error("owed frame dropped while busy");

  a_frame_count: assert property (s_char_end ##0 lastChar |=>
    st_q.frameCnt == 16'($past(st_q.frameCnt) + 16'd1))
    else $error("finished frame not counted");

  a_point_code: assert property (s_load_at(1) |->
    ch[2:0] == st_q.snap.decPoint)
    else $error("decimal point code wrong");

  a_ind_first: assert property (s_load_at(1) ##0 !st_q.frm.spMode |->
    ch[4:3] == st_q.snap.incCode && !ch[6])
    else $error("indicator first byte carries setpoint bits");

  a_sp_first: assert property (s_load_at(1) ##0 st_q.frm.spMode |->
    ch[3] == !st_q.snap.sp1Feed && ch[4] == !st_q.snap.sp2Feed && ch[6])
    else $error("setpoint first byte wrong");

  a_net_sign: assert property (s_load_at(2) |->
    ch[0] == st_q.snap.isNet && ch[1] == st_q.snap.isNeg)
    else $error("net or sign bit wrong");

  a_range_motion: assert property (s_load_at(2) |->
    ch[2] == st_q.snap.outRange && ch[3] == st_q.snap.motion)
    else $error("range or motion bit wrong");

  a_unit_kg: assert property (s_load_at(2) |->
    ch[4] == st_q.snap.isKg)
    else $error("kilogram bit wrong");

  a_unit_code: assert property (s_load_at(3) |->
    ch[2:0] == st_q.snap.unitCode)
    else $error("unit code wrong");

  a_third_std: assert property (s_load_at(3) ##0 !st_q.frm.spMode |->
    ch[6:3] == {2'b01, st_q.snap.expand10, st_q.snap.printReq})
    else $error("standard third byte wrong");

  a_third_sp: assert property (s_load_at(3) ##0 st_q.frm.spMode |->
    ch[6:3] == {3'b111, st_q.snap.printReq})
    else $error("setpoint third byte wrong");

  a_weight_digit: assert property (s_load_span(4, 9) ##0 ch != `CWF_CHR_SPACE |->
    ch == {3'b011, 4'(st_q.snap.weightBcd >> (8'd36 - 8'(st_q.idx) * 8'd4))})
    else $error("weight digit wrong");

  a_tare_digit: assert property (s_load_span(10, 15) ##0 ch != `CWF_CHR_SPACE |->
    ch == {3'b011, 4'(st_q.snap.tareBcd >> (8'd60 - 8'(st_q.idx) * 8'd4))})
    else $error("tare digit wrong");

  a_no_point: assert property (s_load_span(4, 15) |->
    ch != 7'h2e && ch != 7'h2d && ch != 7'h2b)
    else $error("point or sign inside a field");

  a_blank_zero: assert property (s_load_span(4, 9) ##0 ch == `CWF_CHR_SPACE |->
    4'(st_q.snap.weightBcd >> (8'd36 - 8'(st_q.idx) * 8'd4)) == 4'h0)
    else $error("non-zero digit blanked");

  a_units_shown: assert property (s_load_at(9) |->
    ch != `CWF_CHR_SPACE)
    else $error("last weight digit blanked");

  // Bus answer only after a request
  a_wait_req: assert property (!avs_waitrequest |->
    $past(avs_read || avs_write))
    else $error("bus answer without request");

endmodule : cwf_frame_tx

// >>> tb/cwf_uart_rx.sv
// Serial character receiver standing in for the remote display
`timescale 1ns/100ps

module cwf_uart_rx #(
  parameter int DIV = 8
) (
  input wire logic sys_clk,
  input wire logic txd
);
  logic [6:0] rxQ[$];
  logic [8:0] bits;
  int         badCnt = 0;

  always begin
    @(negedge txd);
    repeat (DIV / 2) @(posedge sys_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (DIV) @(posedge sys_clk);
      bits[i] = txd;
    end
    if ((^bits[7:0]) !== 1'b0 || bits[8] !== 1'b1) badCnt++;
    rxQ.push_back(bits[6:0]);
  end
endmodule : cwf_uart_rx

// >>> tb/cwf_frame_tx_test.sv
// Self-checking bench for the continuous weight frame sender
`timescale 1ns/100ps
`define CHK(g, e) check(32'(g), 32'(e));

module cwf_frame_tx_test;
  typedef struct packed {
    cwf_pkg::cwf_ctrl_t c;
    cwf_pkg::cwf_meas_t m;
  } cwf_row_t;

  logic               sys_clk  = 1'b0;
  logic               rst_b    = 1'b0;
  logic               convDone = 1'b0;
  cwf_pkg::cwf_meas_t meas     = '0;
  logic [3:0]         avsAddr  = 4'h0;
  logic               avsRd    = 1'b0;
  logic               avsWr    = 1'b0;
  logic [31:0]        avsWd    = 32'h0;
  logic [31:0]        avsRdData;
  logic               avsWait;
  logic               txd;
  logic [31:0]        rd;
  logic [6:0]         expQ[$];
  int                 fails    = 0;
  int                 cmpCount = 0;
  // Control, weight, tare, point, increment, flags, unit, extra flags
  cwf_row_t           rows[8]  = '{
    {4'h1, 24'h000120, 24'h000000, 3'h2, 2'h0, 6'h21, 3'h0, 5'h00},
    {4'h7, 24'h012345, 24'h000050, 3'h5, 2'h2, 6'h1e, 3'h1, 5'h18},
    {4'hf, 24'h000007, 24'h000300, 3'h3, 2'h1, 6'h01, 3'h2, 5'h15},
    {4'hb, 24'h999999, 24'h100000, 3'h1, 2'h0, 6'h20, 3'h3, 5'h0a},
    {4'h5, 24'h000000, 24'h000001, 3'h4, 2'h1, 6'h08, 3'h4, 5'h10},
    {4'h3, 24'h000100, 24'h000000, 3'h2, 2'h2, 6'h04, 3'h5, 5'h08},
    {4'hd, 24'h040000, 24'h000000, 3'h5, 2'h0, 6'h02, 3'h6, 5'h03},
    {4'h9, 24'h000009, 24'h999999, 3'h4, 2'h1, 6'h3f, 3'h7, 5'h1f}};

  cwf_frame_tx #(.BAUD_DIV(8)) u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .convDone(convDone), .meas(meas),
    .avs_address(avsAddr), .avs_read(avsRd), .avs_write(avsWr), .avs_writedata(avsWd),
    .avs_byteenable(4'hf), .avs_readdata(avsRdData), .avs_waitrequest(avsWait), .txd(txd));

  cwf_uart_rx #(.DIV(8)) u_rx (.sys_clk(sys_clk), .txd(txd));

  // Clock and watchdog
  initial forever #4 sys_clk = ~sys_clk;
  initial begin
    repeat (40000) @(posedge sys_clk);
    fails++;
    wrap_up();
  end

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    cmpCount++;
    if (g !== e) begin
      fails++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask : check

  task automatic wrap_up();
    if (fails == 0 && cmpCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  // Avalon access held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge sys_clk);
    avsAddr <= a;
    avsWr   <= wr;
    avsRd   <= !wr;
    avsWd   <= wd;
    do begin
      @(posedge sys_clk);
    end while (avsWait !== 1'b0);
    d = avsRdData;
    avsRd <= 1'b0;
    avsWr <= 1'b0;
  endtask : bus

  task automatic pulse();
    @(posedge sys_clk);
    convDone <= 1'b1;
    @(posedge sys_clk);
    convDone <= 1'b0;
  endtask : pulse

  // Wait for n characters, then make sure no more follow
  task automatic frame(input int n);
    int k;
    k = 0;
    while (u_rx.rxQ.size() < n && k < 4000) begin
      @(posedge sys_clk);
      k++;
    end
    repeat (300) @(posedge sys_clk);
    `CHK(u_rx.rxQ.size(), n)
  endtask : frame

  // Expected characters of one frame
  function automatic void build(input cwf_row_t r);
    logic [23:0] f[2];
    logic [6:0]  s;
    logic        lead;
    int          u;
    f = '{r.m.weightBcd, r.m.tareBcd};
    u = (r.m.decPoint < 3) ? 5 : 7 - r.m.decPoint;
    expQ = {};
    if (r.c.stx) expQ.push_back(7'h02);
    expQ.push_back(r.c.spMode ? {2'b11, ~r.m.sp2Feed, ~r.m.sp1Feed, r.m.decPoint}
                              : {2'b01, r.m.incCode, r.m.decPoint});
    expQ.push_back({r.c.spMode ? r.m.sp1Tol : r.m.zeroLost, 1'b1, r.m.isKg, r.m.motion,
                    r.m.outRange, r.m.isNeg, r.m.isNet});
    expQ.push_back(r.c.spMode ? {3'b111, r.m.printReq, r.m.unitCode}
                              : {2'b01, r.m.expand10, r.m.printReq, r.m.unitCode});
    for (int j = 0; j < 2; j++) begin
      lead = 1'b1;
      for (int i = 0; i < 6; i++) begin
        lead = lead && f[j][23 - 4 * i -: 4] == 4'h0 && i < u;
        expQ.push_back(lead ? 7'h20 : {3'h3, f[j][23 - 4 * i -: 4]});
      end
    end
    expQ.push_back(7'h0d);
    s = 7'h0;
    foreach (expQ[i]) s += expQ[i];
    if (r.c.chk) expQ.push_back(7'h0 - s);
  endfunction : build

  // Reset, table of frames, then refused and merged conversions
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    `CHK(txd, 1'b1)
    bus(1'b0, 4'h0, 32'h0, rd);
    `CHK(rd, 32'h9)
    bus(1'b0, 4'hc, 32'h0, rd);
    `CHK(rd, 32'h0)
    bus(1'b0, 4'h4, 32'h0, rd);
    `CHK(rd, 32'h8)
    foreach (rows[i]) begin
      bus(1'b1, 4'h0, 32'(rows[i].c), rd);
      meas <= rows[i].m;
      build(rows[i]);
      u_rx.rxQ.delete();
      pulse();
      frame(expQ.size());
      foreach (expQ[k]) `CHK(u_rx.rxQ[k], expQ[k])
    end
    bus(1'b1, 4'h0, 32'h0, rd);
    u_rx.rxQ.delete();
    pulse();
    frame(0);
    bus(1'b1, 4'h0, 32'h1, rd);
    u_rx.rxQ.delete();
    pulse();
    repeat (40) @(posedge sys_clk);
    pulse();
    pulse();
    frame(32);
    bus(1'b0, 4'h8, 32'h0, rd);
    `CHK(rd[31:16], 16'h000a)
    `CHK(u_rx.badCnt, 32'h0)
    wrap_up();
  end
endmodule : cwf_frame_tx_test
